//--- hdl/eipv_pin_cond.sv
// package and pin conditioner for the interrupt priority and vector block
package eipv_pkg;
   // ====================================================================
   // sources and vectors, indexed by tie-break position
   localparam int N_SRC = 20;
   localparam int SRC_W = 5;
   localparam int SRC_EXT0 = 0;
   localparam int SRC_TMR0 = 1;
   localparam int SRC_EXT1 = 2;
   localparam int SRC_SPI = 6;
   localparam int VEC_W = 16;
   localparam logic [VEC_W-1:0] VEC_TABLE [N_SRC] = '{
      16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023,
      16'h002b, 16'h0033, 16'h003b, 16'h0043, 16'h004b,
      16'h0053, 16'h005b, 16'h0063, 16'h0073, 16'h007b,
      16'h0083, 16'h0093, 16'h008b, 16'h009b, 16'h00a3};
   // ====================================================================
   // register port
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_TCTL = 3'h0;
   localparam logic [ADDR_W-1:0] ADDR_EN0 = 3'h1;
   localparam logic [ADDR_W-1:0] ADDR_PRI0 = 3'h4;
   localparam logic [ADDR_W-1:0] ADDR_STAT = 3'h7;
   localparam int PER_REG = 7;
   localparam int TC_EDGE0 = 0;
   localparam int TC_PEND0 = 1;
   localparam int TC_EDGE1 = 2;
   localparam int TC_PEND1 = 3;
   localparam int GEN_BIT = 7;
   localparam int ST_ACT_LO = 0;
   localparam int ST_ACT_HI = 1;
   localparam int ST_BUSY = 2;
   // ====================================================================
   // timing, in system clocks
   localparam int DETECT_CYCLES = 1;
   localparam int LONG_SUBROUTINE_CALL_CYCLES = 4;
   localparam int RETURN_FROM_IRQ_CYCLES = 5;
   localparam int DIV_CYCLES = 8;
   localparam int MIN_RESPONSE = DETECT_CYCLES + LONG_SUBROUTINE_CALL_CYCLES;
   localparam int MAX_RESPONSE = DETECT_CYCLES + RETURN_FROM_IRQ_CYCLES
                                 + DIV_CYCLES + LONG_SUBROUTINE_CALL_CYCLES;
   localparam int CNT_W = 2;
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(LONG_SUBROUTINE_CALL_CYCLES - 1);
   typedef enum logic {ST_IDLE, ST_CALL} eipv_state_t;
endpackage : eipv_pkg

`timescale 1ns/10ps
module eipv_pin_cond (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin_n,
   output logic asserted,
   output logic fall
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
      logic fall;
   } eipv_pin_t;
   eipv_pin_t st_reg;
   eipv_pin_t st_next;

   // ====================================================================
   // three-stage sync; a change counts once stages two and three agree
   always_comb begin
      st_next = st_reg;
      st_next.s1 = pin_n;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      st_next.fall = 1'b0;
      if (st_reg.s2 == st_reg.s3) begin
         st_next.lvl = ~st_reg.s3;
         st_next.fall = ~st_reg.s3 & ~st_reg.lvl;
      end
   end

   // pins idle high, so the chain resets to the idle level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, lvl: 1'b0, fall: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign asserted = st_reg.lvl;
   assign fall = st_reg.fall;
endmodule : eipv_pin_cond

//--- hdl/eipv_irq_ctrl.sv
// interrupt priority decode, vectoring and external pin pending logic
// Summary of operation
// - external inputs active low, level or falling edge
// - pending flags at control bits one and three
// - edge mode pending cleared when call vectors
// - level mode pending follows the pin
// - input zero vectors 0x0003, position zero
// - input one 0x0013 position two, timer one
// - four spi flags merge into vector 0x0033
// - high preempts low; nothing preempts high
// - per-source priority bit, resets to low
// - high level request wins over low
// - equal level: lowest position wins
// - sample and decode requests every clock
// - fastest response five clocks: detect plus call
// - after return, one instruction before next call
// - worst case eighteen clocks: return then divide
// - equal or lower level waits for return
// - global enable bit seven gates all sources
// - flags set regardless of enable; masked ignored
// - flag still set after return re-requests
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module eipv_irq_ctrl
   import eipv_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ext_irq_in_zero,
   input wire logic ext_irq_in_one,
   input wire logic timer_zero_overflow_flag,
   input wire logic spi_transfer_done_flag,
   input wire logic spi_write_collision_flag,
   input wire logic spi_mode_fault_flag,
   input wire logic spi_receive_overrun_flag,
   input wire logic [eipv_pkg::N_SRC-1:0] periph_flag,
   input wire logic [eipv_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [eipv_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [eipv_pkg::DATA_W-1:0] reg_rdata,
   input wire logic core_instr_done,
   input wire logic core_return_from_irq_done,
   output logic call_req,
   output logic call_done,
   output logic [eipv_pkg::VEC_W-1:0] call_vector,
   output logic [eipv_pkg::N_SRC-1:0] src_vectored,
   output logic [1:0] active_level
);
   import eipv_pkg::*;

   typedef struct packed {
      eipv_state_t st;
      logic [CNT_W-1:0] cnt;
      logic [SRC_W-1:0] src;
      logic src_hi;
      logic [VEC_W-1:0] vec;
      logic edge0;
      logic edge1;
      logic pend0;
      logic pend1;
      logic gen;
      logic [N_SRC-1:0] en;
      logic [N_SRC-1:0] pri;
      logic [N_SRC-1:0] req;
      logic act_lo;
      logic act_hi;
      logic [DATA_W-1:0] rdata;
   } eipv_ctrl_t;

   eipv_ctrl_t st_reg;
   eipv_ctrl_t st_next;

   logic lvl0;
   logic fall0;
   logic lvl1;
   logic fall1;
   logic [N_SRC-1:0] pend_all;
   logic [N_SRC-1:0] cand;
   logic [N_SRC-1:0] below_win;
   logic hi_any;
   logic allow_hi;
   logic allow_lo;
   logic win_ok;
   logic win_hi;
   logic [SRC_W-1:0] win;
   logic take;
   logic done;
   logic wr_tctl;

   // ====================================================================
   // pin conditioning
   eipv_pin_cond u_pin0 (
      .clk(clk),
      .rst_n(rst_n),
      .pin_n(ext_irq_in_zero),
      .asserted(lvl0),
      .fall(fall0)
   );

   eipv_pin_cond u_pin1 (
      .clk(clk),
      .rst_n(rst_n),
      .pin_n(ext_irq_in_one),
      .asserted(lvl1),
      .fall(fall1)
   );

   // ====================================================================
   // pending flag gather
   always_comb begin
      pend_all = periph_flag;
      pend_all[SRC_EXT0] = st_reg.pend0;
      pend_all[SRC_TMR0] = timer_zero_overflow_flag;
      pend_all[SRC_EXT1] = st_reg.pend1;
      pend_all[SRC_SPI] = spi_transfer_done_flag
                          | spi_write_collision_flag
                          | spi_mode_fault_flag
                          | spi_receive_overrun_flag;
   end

   // ====================================================================
   // arbitration over the sampled requests
   always_comb begin
      hi_any = |(st_reg.req & st_reg.pri);
      allow_hi = ~st_reg.act_hi;
      allow_lo = ~st_reg.act_hi & ~st_reg.act_lo;
      win_hi = hi_any & allow_hi;
      if (win_hi) begin
         cand = st_reg.req & st_reg.pri;
      end else if (allow_lo) begin
         cand = st_reg.req & ~st_reg.pri;
      end else begin
         cand = '0;
      end
      win_ok = 1'b0;
      win = '0;
      for (int i = N_SRC - 1; i >= 0; i--) begin
         if (cand[i]) begin
            win_ok = 1'b1;
            win = SRC_W'(i);
         end
      end
      below_win = ~({N_SRC{1'b1}} << win);
   end

   assign wr_tctl = reg_wr && (reg_addr == ADDR_TCTL);

   // ====================================================================
   // next state
   always_comb begin
      st_next = st_reg;
      take = 1'b0;
      done = 1'b0;

      // call sequencer
      unique case (st_reg.st)
         ST_IDLE: begin
            if (core_instr_done && core_return_from_irq_done) begin
               // return closes the innermost active level
               if (st_reg.act_hi) begin
                  st_next.act_hi = 1'b0;
               end else begin
                  st_next.act_lo = 1'b0;
               end
            end else if (core_instr_done && win_ok) begin
               // never on the return boundary: one instruction runs first
               take = 1'b1;
               st_next.st = ST_CALL;
               st_next.cnt = '0;
               st_next.src = win;
               st_next.src_hi = win_hi;
               st_next.vec = VEC_TABLE[win];
            end
         end
         ST_CALL: begin
            if (st_reg.cnt == CNT_LAST) begin
               done = 1'b1;
               st_next.st = ST_IDLE;
               if (st_reg.src_hi) begin
                  st_next.act_hi = 1'b1;
               end else begin
                  st_next.act_lo = 1'b1;
               end
            end else begin
               st_next.cnt = st_reg.cnt + 1'b1;
            end
         end
      endcase

      // external pending flags; a hardware set beats any clear
      if (wr_tctl) begin
         st_next.edge0 = reg_wdata[TC_EDGE0];
         st_next.edge1 = reg_wdata[TC_EDGE1];
      end
      if (st_reg.edge0) begin
         if (wr_tctl) begin
            st_next.pend0 = reg_wdata[TC_PEND0];
         end
         if (done && st_reg.src == SRC_W'(SRC_EXT0)) begin
            st_next.pend0 = 1'b0;
         end
         if (fall0) begin
            st_next.pend0 = 1'b1;
         end
      end else begin
         st_next.pend0 = lvl0;
      end
      if (st_reg.edge1) begin
         if (wr_tctl) begin
            st_next.pend1 = reg_wdata[TC_PEND1];
         end
         if (done && st_reg.src == SRC_W'(SRC_EXT1)) begin
            st_next.pend1 = 1'b0;
         end
         if (fall1) begin
            st_next.pend1 = 1'b1;
         end
      end else begin
         st_next.pend1 = lvl1;
      end

      // enable and priority registers, seven sources per register
      if (reg_wr && reg_addr == ADDR_EN0) begin
         st_next.gen = reg_wdata[GEN_BIT];
      end
      for (int i = 0; i < N_SRC; i++) begin
         if (reg_wr && reg_addr == ADDR_EN0 + ADDR_W'(i / PER_REG)) begin
            st_next.en[i] = reg_wdata[i % PER_REG];
         end
         if (reg_wr && reg_addr == ADDR_PRI0 + ADDR_W'(i / PER_REG)) begin
            st_next.pri[i] = reg_wdata[i % PER_REG];
         end
      end

      // detect stage: masked pending sampled every clock
      st_next.req = pend_all & st_reg.en & {N_SRC{st_reg.gen}};

      // read data, valid the cycle after the strobe only
      st_next.rdata = '0;
      if (reg_rd) begin
         if (reg_addr == ADDR_TCTL) begin
            st_next.rdata[TC_EDGE0] = st_reg.edge0;
            st_next.rdata[TC_PEND0] = st_reg.pend0;
            st_next.rdata[TC_EDGE1] = st_reg.edge1;
            st_next.rdata[TC_PEND1] = st_reg.pend1;
         end
         if (reg_addr == ADDR_EN0) begin
            st_next.rdata[GEN_BIT] = st_reg.gen;
         end
         if (reg_addr == ADDR_STAT) begin
            st_next.rdata[ST_ACT_LO] = st_reg.act_lo;
            st_next.rdata[ST_ACT_HI] = st_reg.act_hi;
            st_next.rdata[ST_BUSY] = (st_reg.st == ST_CALL);
         end
         for (int i = 0; i < N_SRC; i++) begin
            if (reg_addr == ADDR_EN0 + ADDR_W'(i / PER_REG)) begin
               st_next.rdata[i % PER_REG] = st_reg.en[i];
            end
            if (reg_addr == ADDR_PRI0 + ADDR_W'(i / PER_REG)) begin
               st_next.rdata[i % PER_REG] = st_reg.pri[i];
            end
         end
      end
   end

   // ====================================================================
   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0; // all priorities low, everything masked
      end else begin
         st_reg <= st_next;
      end
   end

   // ====================================================================
   // outputs
   assign reg_rdata = st_reg.rdata;
   assign call_req = (st_reg.st == ST_CALL);
   assign call_done = done;
   assign call_vector = st_reg.vec;
   assign src_vectored = done ? (N_SRC'(1) << st_reg.src) : '0;
   assign active_level = {st_reg.act_hi, st_reg.act_lo};

   // ====================================================================
   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_long_subroutine_call;
      (call_req && !call_done) [*3] ##1 (call_req && call_done);
   endsequence

   sequence s_call_end;
      s_long_subroutine_call ##1 !call_req;
   endsequence

   property p_min_resp;
      take |=> s_call_end;
   endproperty
   a_min_resp: assert property (p_min_resp)
      else $error("call did not last four clocks");

   property p_level_follow;
      (!st_reg.edge0 && !st_next.edge0) |=> (st_reg.pend0 == $past(lvl0));
   endproperty
   a_level_follow: assert property (p_level_follow)
      else $error("level pending does not follow the pin");

   property p_edge_clear;
      (done && st_reg.src == SRC_W'(SRC_EXT0) && st_reg.edge0 && !fall0
       && !wr_tctl) |=> !st_reg.pend0;
   endproperty
   a_edge_clear: assert property (p_edge_clear)
      else $error("edge pending not cleared on vectoring");

   property p_no_preempt_hi;
      st_reg.act_hi |-> !take;
   endproperty
   a_no_preempt_hi: assert property (p_no_preempt_hi)
      else $error("high level routine was preempted");

   property p_return_from_irq_gap;
      (core_instr_done && core_return_from_irq_done) |-> !take;
   endproperty
   a_return_from_irq_gap: assert property (p_return_from_irq_gap)
      else $error("call taken on the return boundary");

   property p_high_first;
      (take && hi_any && !st_reg.act_hi) |-> st_reg.pri[win];
   endproperty
   a_high_first: assert property (p_high_first)
      else $error("low level won over a high level request");

   property p_lowest_pos;
      take |-> ((cand & below_win) == '0) && cand[win];
   endproperty
   a_lowest_pos: assert property (p_lowest_pos)
      else $error("tie-break did not pick the lowest position");

   property p_global_mask;
      !st_reg.gen |=> (st_reg.req == '0);
   endproperty
   a_global_mask: assert property (p_global_mask)
      else $error("request sampled while globally masked");

   property p_vector;
      take |=> (call_vector == VEC_TABLE[$past(win)])
               ##1 $stable(call_vector) [*3];
   endproperty
   a_vector: assert property (p_vector)
      else $error("vector wrong or unstable during call");

   property p_level_track;
      (call_done && st_reg.src_hi) |=> active_level[1];
   endproperty
   a_level_track: assert property (p_level_track)
      else $error("active high level not recorded");
endmodule : eipv_irq_ctrl

//--- tb/eipv_core_model.sv
// sequencer model on the far side of the interrupt controller
`timescale 1ns/10ps
module eipv_core_model
   import eipv_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic call_req,
   input wire logic ret_tog,
   output logic core_instr_done,
   output logic core_return_from_irq_done
);
   // ====================================================================
   // instruction stream: one-clock ops, a return on each toggle
   logic [3:0] left_reg;
   logic in_ret_reg;
   logic seen_reg;
   // sequencer is busy while the call runs, so no boundary is shown
   assign core_instr_done = !call_req && left_reg == 4'h0;
   assign core_return_from_irq_done = core_instr_done && in_ret_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         left_reg <= 4'h0;
         in_ret_reg <= 1'b0;
         seen_reg <= 1'b0;
      end else if (!call_req) begin
         if (left_reg != 4'h0) begin
            left_reg <= left_reg - 4'h1;
         end else if (ret_tog != seen_reg) begin
            seen_reg <= ret_tog;
            in_ret_reg <= 1'b1;
            left_reg <= 4'(RETURN_FROM_IRQ_CYCLES - 1);
         end else begin
            // a divide after every return gives the slowest path
            left_reg <= in_ret_reg ? 4'(DIV_CYCLES - 1) : 4'h0;
            in_ret_reg <= 1'b0;
         end
      end
   end
endmodule : eipv_core_model

//--- tb/ext_irq_priority_vectoring_bench.sv
// self-checking bench for the interrupt priority and vector block
`timescale 1ns/10ps
module ext_irq_priority_vectoring_bench;
   import eipv_pkg::*;
   logic clk, rst_n, pin0, pin1, tmr, ret_tog, reg_wr, reg_rd;
   logic [3:0] spi;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata;
   logic call_req, call_done, core_instr_done, core_return_from_irq_done;
   logic [VEC_W-1:0] call_vector;
   logic [N_SRC-1:0] src_vectored, pflag;
   logic [1:0] active_level;
   int err_count = 0;
   int tests_run = 0;
   eipv_irq_ctrl dut (.clk(clk), .rst_n(rst_n), .ext_irq_in_zero(pin0),
      .ext_irq_in_one(pin1), .timer_zero_overflow_flag(tmr),
      .spi_transfer_done_flag(spi[0]), .spi_write_collision_flag(spi[1]),
      .spi_mode_fault_flag(spi[2]), .spi_receive_overrun_flag(spi[3]),
      .periph_flag(pflag), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .core_instr_done(core_instr_done), .core_return_from_irq_done(core_return_from_irq_done),
      .call_req(call_req), .call_done(call_done),
      .call_vector(call_vector), .src_vectored(src_vectored),
      .active_level(active_level));
   eipv_core_model core (.clk(clk), .rst_n(rst_n), .call_req(call_req),
      .ret_tog(ret_tog), .core_instr_done(core_instr_done),
      .core_return_from_irq_done(core_return_from_irq_done));
   // ====================================================================
   // tasks
   task automatic final_report();
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : final_report
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(20'(reg_rdata), 20'(e));
   endtask : rd
   task automatic call_wait(input int s, input logic [15:0] v, input int m);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (call_done !== 1'b1 && n < 60);
      if (n >= 60) begin
         err_count++;
         final_report();
      end
      chk(20'(call_vector), 20'(v));
      chk(20'(src_vectored), 20'h1 << s);
      if (m > 0) chk(20'(n), 20'(m));
   endtask : call_wait
   task automatic ret();
      int n;
      n = 0;
      @(posedge clk);
      ret_tog <= ~ret_tog;
      do begin
         @(posedge clk);
         #1 n++;
      end while (core_return_from_irq_done !== 1'b1 && n < 40);
      if (n >= 40) begin
         err_count++;
         final_report();
      end
   endtask : ret
   task automatic quiet(input int c);
      logic bad;
      bad = 1'b0;
      repeat (c) begin
         @(posedge clk);
         #1 if (call_req !== 1'b0) bad = 1'b1;
      end
      chk(20'(bad), 20'h0);
   endtask : quiet
   task automatic lvl(input logic [1:0] e);
      @(posedge clk);
      #1 chk(20'(active_level), 20'(e));
   endtask : lvl
   // ====================================================================
   // clock, reset, sequence
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      {rst_n, tmr, ret_tog, reg_wr, reg_rd, pflag} = '0;
      {pin0, pin1, spi, reg_addr, reg_wdata} = {2'b11, 4'h0, 3'h0, 8'h00};
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      rd(ADDR_TCTL, 8'h00);
      for (int a = 4; a < 7; a++) rd(3'(a), 8'h00);
      wr(ADDR_STAT, 8'hff);
      rd(ADDR_STAT, 8'h00);
      // fastest path, then held-off equal level and return latency
      wr(ADDR_EN0, 8'h82);
      @(posedge clk);
      tmr <= 1'b1;
      call_wait(SRC_TMR0, 16'h000b, MIN_RESPONSE);
      lvl(2'b01);
      quiet(10);
      ret();
      call_wait(SRC_TMR0, 16'h000b,
         DIV_CYCLES + LONG_SUBROUTINE_CALL_CYCLES);
      // high preempts low, nothing preempts high
      wr(3'h4, 8'h40);
      wr(ADDR_EN0, 8'hc2);
      @(posedge clk);
      spi[2] <= 1'b1;
      call_wait(SRC_SPI, 16'h0033, 0);
      lvl(2'b11);
      wr(3'h4, 8'h42);
      quiet(12);
      @(posedge clk);
      tmr <= 1'b0;
      spi <= 4'h0;
      ret();
      lvl(2'b01);
      ret();
      lvl(2'b00);
      // arbitration over every spi flag, both levels
      for (int k = 0; k < 8; k++) begin
         wr(3'h4, k[2] ? 8'h00 : 8'h40);
         @(posedge clk);
         tmr <= 1'b1;
         spi[k[1:0]] <= 1'b1;
         if (k[2])
            call_wait(SRC_TMR0, 16'h000b, 0);
         else
            call_wait(SRC_SPI, 16'h0033, 0);
         @(posedge clk);
         tmr <= 1'b0;
         spi <= 4'h0;
         ret();
      end
      // level input zero; source releases inside its routine
      wr(ADDR_EN0, 8'h81);
      @(posedge clk);
      pin0 <= 1'b0;
      call_wait(SRC_EXT0, 16'h0003, 0);
      rd(ADDR_TCTL, 8'h02);
      @(posedge clk);
      pin0 <= 1'b1;
      repeat (6) @(posedge clk);
      rd(ADDR_TCTL, 8'h00);
      ret();
      quiet(15);
      // edge input one, latched while masked, cleared on vectoring
      wr(ADDR_TCTL, 8'h04);
      wr(ADDR_EN0, 8'h04);
      @(posedge clk);
      pin1 <= 1'b0;
      repeat (3) @(posedge clk);
      pin1 <= 1'b1;
      quiet(8);
      rd(ADDR_TCTL, 8'h0c);
      wr(ADDR_EN0, 8'h84);
      call_wait(SRC_EXT1, 16'h0013, 0);
      rd(ADDR_TCTL, 8'h04);
      ret();
      // edge input zero: software set and clear, then a pin edge
      wr(ADDR_TCTL, 8'h01);
      wr(ADDR_TCTL, 8'h03);
      rd(ADDR_TCTL, 8'h03);
      wr(ADDR_TCTL, 8'h01);
      rd(ADDR_TCTL, 8'h01);
      wr(ADDR_EN0, 8'h81);
      @(posedge clk);
      pin0 <= 1'b0;
      call_wait(SRC_EXT0, 16'h0003, 0);
      rd(ADDR_TCTL, 8'h01);
      @(posedge clk);
      pin0 <= 1'b1;
      ret();
      quiet(15);
      // upper sources through the shared flag port, both levels
      wr(3'h1, 8'h80);
      wr(3'h2, 8'h40);
      wr(3'h3, 8'h20);
      for (int k = 0; k < 2; k++) begin
         wr(3'h6, k[0] ? 8'h00 : 8'h20);
         @(posedge clk);
         pflag <= 20'h82000;
         if (k[0])
            call_wait(13, 16'h0073, 0);
         else
            call_wait(19, 16'h00a3, 0);
         @(posedge clk);
         pflag <= '0;
         ret();
      end
      final_report();
   end
endmodule : ext_irq_priority_vectoring_bench
